// file: inc/tbid_defs.svh
// Constants for the twelve-bit instruction decoder: field positions and timing
`ifndef TBID_DEFS_SVH
`define TBID_DEFS_SVH

// ****************************************************************
// Word and field layout
// ****************************************************************
`define TBID_WORD_W        12
`define TBID_OPB_MSB       11
`define TBID_OPB_LSB       6
`define TBID_DEST_BIT      5
`define TBID_SEL_MSB       4
`define TBID_SEL_LSB       0
`define TBID_OPS_LSB       8
`define TBID_POS_MSB       7
`define TBID_POS_LSB       5
`define TBID_IMM_MSB       7
`define TBID_OPJ_LSB       9
`define TBID_JIMM_MSB      8
`define TBID_ADDR_MAX      7'h7F

// ****************************************************************
// Instruction cycle timing
// ****************************************************************
`define TBID_PHASES        4
`define TBID_RST_WORD      12'h000

`endif

// file: inc/tbid_pkg.sv
// Types shared by the twelve-bit instruction decoder
package tbid_pkg;

  // Instruction group, one-hot
  typedef enum logic [2:0] {
    TBID_GRP_BYTE = 3'b001,
    TBID_GRP_BIT  = 3'b010,
    TBID_GRP_IMM  = 3'b100
  } tbid_grp_e;

  // Fetch sequencer state, one-hot
  typedef enum logic [1:0] {
    TBID_ST_RUN   = 2'b01,
    TBID_ST_FLUSH = 2'b10
  } tbid_st_e;

endpackage

// file: core/tbid_decode.sv
// Twelve-bit instruction decoder with four-phase instruction cycle timing
// Operation
// [RQ1] Each instruction is one 12-bit word: opcode plus operand fields.
// [RQ2] Every word falls into exactly one group: byte, bit, or immediate/control.
// [RQ3] Byte ops: destination flag 0 targets accumulator, 1 targets the file register.
// [RQ4] Register selector is a data address within 0x00 to 0x7F.
// [RQ5] Bit ops: position index picks one bit of the 8-bit register.
// [RQ6] Immediate is 8 bits, or 9 bits for the unconditional jump.
// [RQ7] One instruction cycle normally; two on true skip or program counter change.
// [RQ8] An instruction cycle is four consecutive clock periods, fetch and execute phases.
// [RQ9] Don't-care bits are ignored; tools should write them as zero.
// [RQ10] Byte ops: opcode 11:6, destination flag 5, selector 4:0.
// [RQ11] Immediate ops except jump: opcode 11:8, immediate 7:0.
// [RQ12] Jump: opcode 11:9, 9-bit immediate 8:0 is the target.
// [RQ13] Bit ops: opcode 11:8, position index 7:5, selector 4:0.
// [RQ14] Two-cycle instructions drop the prefetched word and run a no-operation cycle.
`timescale 1ns/100ps
`include "tbid_defs.svh"

module tbid_decode #(
  parameter int WORD_W = `TBID_WORD_W,
  parameter int PHASES = `TBID_PHASES
) (
  // Clock and reset
  input  wire logic              clk_i,
  input  wire logic              rst_i,
  // Program memory word and execution feedback
  input  wire logic [11:0]       word_i,
  input  wire logic              cond_true_i,
  // Phase strobes
  output logic                   fetch_o,
  output logic                   exec_o,
  output logic [1:0]             phase_o,
  // Decoded fields
  output logic                   valid_o,
  output logic [2:0]             group_o,
  output logic [5:0]             opcode_o,
  output logic                   result_target_flag_o,
  output logic [4:0]             register_selector_o,
  output logic [2:0]             position_index_o,
  output logic [8:0]             immediate_value_o,
  output logic                   is_jump_o,
  output logic                   two_cycle_o,
  output logic                   flush_o
);

  // Elaboration check: the field map is fixed to a 12-bit word and four phases
  if (WORD_W != 12 || PHASES != 4) begin : g_bad_param
    $error("tbid_decode supports only 12-bit words and four phases");
  end

  // ****************************************************************
  // Phase divider
  // ****************************************************************
  logic [1:0] phase_reg, phase_next;

  // Four clock periods make one instruction cycle
  always_comb begin
    phase_next = phase_reg + 2'd1; // [RQ8]
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      phase_reg <= 2'd0;
    end else begin
      phase_reg <= phase_next;
    end
  end

  // ****************************************************************
  // Fetch and decode
  // ****************************************************************
  tbid_pkg::tbid_st_e st_reg, st_next;
  logic [11:0] ir_reg, ir_next;
  logic        valid_reg, valid_next;
  logic [2:0]  grp_reg, grp_next;
  logic [5:0]  op_reg, op_next;
  logic        dst_reg, dst_next;
  logic [4:0]  sel_reg, sel_next;
  logic [2:0]  pos_reg, pos_next;
  logic [8:0]  imm_reg, imm_next;
  logic        jmp_reg, jmp_next;
  logic        two_reg, two_next;
  logic        flush_reg, flush_next;
  logic        fetch_reg, fetch_next;
  logic        exec_reg, exec_next;
  logic        is_skip, fixed_two;
  logic [11:0] w;

  // Word latches at phase 3 end so fields are stable for a whole instruction cycle
  always_comb begin
    w          = ir_reg;
    st_next    = st_reg;
    ir_next    = ir_reg;
    valid_next = valid_reg;
    flush_next = 1'b0;
    fetch_next = (phase_next == 2'd3);
    exec_next  = (phase_next == 2'd0);
    if (phase_reg == 2'd3) begin
      case (st_reg)
        tbid_pkg::TBID_ST_RUN: begin
          if (two_reg) begin
            // Prefetched word discarded, bubble runs as no-operation
            ir_next    = `TBID_RST_WORD; // [RQ14]
            valid_next = 1'b0;
            flush_next = 1'b1;
            st_next    = tbid_pkg::TBID_ST_FLUSH;
          end else begin
            ir_next    = word_i; // [RQ1]
            valid_next = 1'b1;
          end
        end
        tbid_pkg::TBID_ST_FLUSH: begin
          ir_next    = word_i;
          valid_next = 1'b1;
          st_next    = tbid_pkg::TBID_ST_RUN;
        end
        default: begin
          st_next    = tbid_pkg::TBID_ST_RUN;
          valid_next = 1'b0;
        end
      endcase
    end
    w = ir_next;
    // Group by top bits: 00 byte, 01 bit, 1x immediate/control
    case (w[11:10])
      2'b00:   grp_next = tbid_pkg::TBID_GRP_BYTE; // [RQ2]
      2'b01:   grp_next = tbid_pkg::TBID_GRP_BIT;
      default: grp_next = tbid_pkg::TBID_GRP_IMM;
    endcase
    jmp_next = (w[11:9] == 3'b101);
    dst_next = 1'b0;
    sel_next = 5'd0;
    pos_next = 3'd0;
    imm_next = 9'd0;
    op_next  = 6'd0;
    // Fields not used by the group stay zero, so don't-care bits never leak
    if (grp_next == tbid_pkg::TBID_GRP_BYTE) begin
      op_next  = w[`TBID_OPB_MSB:`TBID_OPB_LSB]; // [RQ10]
      dst_next = w[`TBID_DEST_BIT];              // [RQ3]
      sel_next = w[`TBID_SEL_MSB:`TBID_SEL_LSB]; // [RQ4]
    end else if (grp_next == tbid_pkg::TBID_GRP_BIT) begin
      op_next  = {2'b00, w[11:`TBID_OPS_LSB]};   // [RQ13]
      pos_next = w[`TBID_POS_MSB:`TBID_POS_LSB]; // [RQ5]
      sel_next = w[`TBID_SEL_MSB:`TBID_SEL_LSB];
    end else if (jmp_next) begin
      op_next  = {3'b000, w[11:`TBID_OPJ_LSB]};  // [RQ12]
      imm_next = w[`TBID_JIMM_MSB:0];            // [RQ6]
    end else begin
      op_next  = {2'b00, w[11:`TBID_OPS_LSB]};   // [RQ11]
      imm_next = {1'b0, w[`TBID_IMM_MSB:0]};
    end
    // Classify the word in execution; bits of no field are never a decision input [RQ9]
    is_skip   = (ir_reg[11:9] == 3'b011) || (ir_reg[11:6] == 6'b001011) || (ir_reg[11:6] == 6'b001111);
    fixed_two = (ir_reg[11:10] == 2'b10);
    two_next  = two_reg;
    if (phase_reg == 2'd3) begin
      two_next = 1'b0;
    end else if (phase_reg == 2'd2 && valid_reg) begin
      // Taken skip or program counter change adds a second cycle [RQ7]
      two_next = fixed_two || (is_skip && cond_true_i);
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_reg    <= tbid_pkg::TBID_ST_RUN;
      ir_reg    <= `TBID_RST_WORD;
      valid_reg <= 1'b0;
      grp_reg   <= tbid_pkg::TBID_GRP_BYTE;
      op_reg    <= 6'd0;
      dst_reg   <= 1'b0;
      sel_reg   <= 5'd0;
      pos_reg   <= 3'd0;
      imm_reg   <= 9'd0;
      jmp_reg   <= 1'b0;
      two_reg   <= 1'b0;
      flush_reg <= 1'b0;
      fetch_reg <= 1'b0;
      exec_reg  <= 1'b0;
    end else begin
      st_reg    <= st_next;
      ir_reg    <= ir_next;
      valid_reg <= valid_next;
      grp_reg   <= grp_next;
      op_reg    <= op_next;
      dst_reg   <= dst_next;
      sel_reg   <= sel_next;
      pos_reg   <= pos_next;
      imm_reg   <= imm_next;
      jmp_reg   <= jmp_next;
      two_reg   <= two_next;
      flush_reg <= flush_next;
      fetch_reg <= fetch_next;
      exec_reg  <= exec_next;
    end
  end

  // Outputs straight from flops
  assign phase_o              = phase_reg;
  assign fetch_o              = fetch_reg;
  assign exec_o               = exec_reg;
  assign valid_o              = valid_reg;
  assign group_o              = grp_reg;
  assign opcode_o             = op_reg;
  assign result_target_flag_o = dst_reg;
  assign register_selector_o  = sel_reg;
  assign position_index_o     = pos_reg;
  assign immediate_value_o    = imm_reg;
  assign is_jump_o            = jmp_reg;
  assign two_cycle_o          = two_reg;
  assign flush_o              = flush_reg;

  // ****************************************************************
  // Assertions
  // ****************************************************************
  AST_PHASE_WRAP: assert property (@(posedge clk_i) disable iff (rst_i) // [RQ8]
    phase_reg == 2'd3 |=> phase_reg == 2'd0) else $error("phase did not wrap");
  AST_FETCH_EVERY4: assert property (@(posedge clk_i) disable iff (rst_i) // [RQ8]
    fetch_reg |-> ##4 fetch_reg) else $error("fetch strobe not every four clocks");
  AST_ONE_GROUP: assert property (@(posedge clk_i) disable iff (rst_i) // [RQ2]
    $onehot(grp_reg)) else $error("group not one-hot");
  AST_BYTE_FIELDS: assert property (@(posedge clk_i) disable iff (rst_i) // [RQ10]
    grp_reg == tbid_pkg::TBID_GRP_BYTE |-> op_reg == ir_reg[11:6] && sel_reg == ir_reg[4:0]
      && dst_reg == ir_reg[5]) else $error("byte field split wrong");
  AST_BIT_FIELDS: assert property (@(posedge clk_i) disable iff (rst_i) // [RQ13]
    grp_reg == tbid_pkg::TBID_GRP_BIT |-> pos_reg == ir_reg[7:5] && imm_reg == 9'd0)
    else $error("bit field split wrong");
  AST_JUMP_IMM: assert property (@(posedge clk_i) disable iff (rst_i) // [RQ12]
    jmp_reg |-> imm_reg == ir_reg[8:0] && op_reg == 6'b000101) else $error("jump target wrong");
  AST_LIT_IMM: assert property (@(posedge clk_i) disable iff (rst_i) // [RQ11]
    grp_reg == tbid_pkg::TBID_GRP_IMM && !jmp_reg |-> imm_reg[8] == 1'b0
      && imm_reg[7:0] == ir_reg[7:0]) else $error("literal wrong");
  AST_FLUSH_BUBBLE: assert property (@(posedge clk_i) disable iff (rst_i) // [RQ14]
    flush_reg |-> !valid_reg && ir_reg == 12'h000 ##4 valid_reg) else $error("no bubble after two-cycle op");
  AST_TWO_CYCLE: assert property (@(posedge clk_i) disable iff (rst_i) // [RQ7]
    phase_reg == 2'd2 && valid_reg && ir_reg[11:10] == 2'b10 |=> two_reg ##1 flush_reg)
    else $error("branch not two cycles");
  AST_SKIP_TWO: assert property (@(posedge clk_i) disable iff (rst_i) // [RQ7]
    phase_reg == 2'd2 && valid_reg && ir_reg[11:9] == 3'b011 && cond_true_i |=> two_reg ##1 flush_reg)
    else $error("taken bit test skip not two cycles");
  AST_ONE_CYCLE: assert property (@(posedge clk_i) disable iff (rst_i) // [RQ7]
    phase_reg == 2'd2 && valid_reg && ir_reg[11:9] == 3'b000 |=> !two_reg ##1 !flush_reg)
    else $error("plain byte op took two cycles");

  COV_BYTE: cover property (@(posedge clk_i) valid_reg && grp_reg == tbid_pkg::TBID_GRP_BYTE);
  COV_BIT: cover property (@(posedge clk_i) valid_reg && grp_reg == tbid_pkg::TBID_GRP_BIT);
  COV_JUMP: cover property (@(posedge clk_i) valid_reg && jmp_reg);
  COV_FLUSH: cover property (@(posedge clk_i) flush_reg);

endmodule // tbid_decode

// file: verif/tbid_prog_mem.sv
// Program memory model that feeds twelve-bit words to the decoder
`timescale 1ns/100ps

module tbid_prog_mem (
  // Clock
  input  wire logic        clk_i,
  // Fetch request
  input  wire logic        fetch_i,
  input  wire logic [3:0]  addr_i,
  // Instruction word
  output logic      [11:0] word_o
);
  logic [11:0] mem [16];
  logic [11:0] last_reg = 12'h000;

  // ****************************************************************
  // Storage and read port
  // ****************************************************************
  // Words are kept as the assembler emits them, don't-care bits at zero
  task automatic load(input logic [3:0] a, input logic [11:0] w);
    mem[a] = w;
  endtask

  // Remember the word just fetched so the idle bus can show its inverse
  always_ff @(posedge clk_i) begin
    if (fetch_i) begin
      last_reg <= mem[addr_i];
    end
  end

  // Outside the fetch phase the bus holds nothing valid, so never the last word
  always_comb begin
    word_o = fetch_i ? mem[addr_i] : ~last_reg;
  end
endmodule // tbid_prog_mem

// file: verif/testbench.sv
// Self-checking bench for the twelve-bit instruction decoder
`timescale 1ns/100ps

module testbench;
  // Table row: word and condition, expected fields and cycle count
  typedef struct packed {
    logic [11:0] word;
    logic        cond;
    logic [27:0] fields;  // Group, opcode, flag, selector, position, immediate, jump
    logic        two;
  } tbid_row_s;
  localparam int NROWS = 13;
  tbid_row_s rows [NROWS] = '{
    '{12'h1FF, 1'h0, {3'h1, 6'h07, 1'h1, 5'h1F, 3'h0, 9'h000, 1'h0}, 1'h0},
    '{12'h145, 1'h0, {3'h1, 6'h05, 1'h0, 5'h05, 3'h0, 9'h000, 1'h0}, 1'h0},
    '{12'h5EA, 1'h1, {3'h2, 6'h05, 1'h0, 5'h0A, 3'h7, 9'h000, 1'h0}, 1'h0},
    '{12'h623, 1'h1, {3'h2, 6'h06, 1'h0, 5'h03, 3'h1, 9'h000, 1'h0}, 1'h1},
    '{12'h623, 1'h0, {3'h2, 6'h06, 1'h0, 5'h03, 3'h1, 9'h000, 1'h0}, 1'h0},
    '{12'hCA5, 1'h0, {3'h4, 6'h0C, 1'h0, 5'h00, 3'h0, 9'h0A5, 1'h0}, 1'h0},
    '{12'hBFF, 1'h0, {3'h4, 6'h05, 1'h0, 5'h00, 3'h0, 9'h1FF, 1'h1}, 1'h1},
    '{12'h9C3, 1'h0, {3'h4, 6'h09, 1'h0, 5'h00, 3'h0, 9'h0C3, 1'h0}, 1'h1},
    '{12'h2E1, 1'h1, {3'h1, 6'h0B, 1'h1, 5'h01, 3'h0, 9'h000, 1'h0}, 1'h1},
    '{12'h004, 1'h1, {3'h1, 6'h00, 1'h0, 5'h04, 3'h0, 9'h000, 1'h0}, 1'h0},
    '{12'hFFF, 1'h1, {3'h4, 6'h0F, 1'h0, 5'h00, 3'h0, 9'h0FF, 1'h0}, 1'h0},
    '{12'h3C2, 1'h1, {3'h1, 6'h0F, 1'h0, 5'h02, 3'h0, 9'h000, 1'h0}, 1'h1},
    '{12'h87E, 1'h0, {3'h4, 6'h08, 1'h0, 5'h00, 3'h0, 9'h07E, 1'h0}, 1'h1}
  };
  logic        clk_i, rst_i, cond_true_i, fetch_o, exec_o, valid_o, result_target_flag_o;
  logic        is_jump_o, two_cycle_o, flush_o;
  logic [11:0] word_i;
  logic [1:0]  phase_o, ph;
  logic [2:0]  group_o, position_index_o;
  logic [5:0]  opcode_o;
  logic [4:0]  register_selector_o;
  logic [8:0]  immediate_value_o;
  logic [3:0]  addr;
  int          fail_count = 0;
  int          num_checks = 0;

  tbid_decode tbid_decode_inst (.clk_i(clk_i), .rst_i(rst_i), .word_i(word_i), .cond_true_i(cond_true_i),
    .fetch_o(fetch_o), .exec_o(exec_o), .phase_o(phase_o), .valid_o(valid_o), .group_o(group_o),
    .opcode_o(opcode_o), .result_target_flag_o(result_target_flag_o), .register_selector_o(register_selector_o),
    .position_index_o(position_index_o), .immediate_value_o(immediate_value_o), .is_jump_o(is_jump_o),
    .two_cycle_o(two_cycle_o), .flush_o(flush_o));
  tbid_prog_mem tbid_prog_mem_inst (.clk_i(clk_i), .fetch_i(fetch_o), .addr_i(addr), .word_o(word_i));

  // ****************************************************************
  // Shared tasks
  // ****************************************************************
  task automatic check_vec(input logic [31:0] got, input logic [31:0] exp, input string what);
    num_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("MISMATCH at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  // Bounded wait, so a stuck phase counter cannot hang the run
  task automatic wait_phase(input logic [1:0] p);
    int n;
    n = 0;
    do begin
      @(posedge clk_i);
      #1;
      n++;
    end while (phase_o !== p && n < 12);
    check_vec({30'h0, phase_o}, {30'h0, p}, "phase wait");
  endtask

  // Present one word in its fetch phase and follow it through its cycle
  task automatic run_row(input tbid_row_s r, input logic [3:0] a);
    wait_phase(2'h2);
    @(posedge clk_i);
    addr <= a;
    cond_true_i <= r.cond;
    @(posedge clk_i);
    #1;
    check_vec({group_o, opcode_o, result_target_flag_o, register_selector_o, position_index_o,
      immediate_value_o, is_jump_o}, r.fields, "fields");
    check_vec({valid_o, exec_o}, 2'h3, "valid and execute");
    repeat (3) @(posedge clk_i);
    #1;
    check_vec({two_cycle_o, fetch_o, phase_o}, {r.two, 3'h7}, "cycle count");
    @(posedge clk_i);
    #1;
    check_vec({flush_o, valid_o}, {r.two, ~r.two}, "bubble");
    if (r.two) check_vec(opcode_o, 6'h00, "bubble opcode");
  endtask

  task automatic finish_test;
    $display("Checks %0d, mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // ****************************************************************
  // Clock, watchdog and main sequence
  // ****************************************************************
  initial begin
    clk_i = 1'b0;
    forever #12.5 clk_i = ~clk_i;
  end

  // About twenty-three times the expected run length
  initial begin
    #75000;
    fail_count++;
    finish_test();
  end

  initial begin
    rst_i = 1'b1;
    cond_true_i = 1'b0;
    addr = 4'h0;
    for (int i = 0; i < NROWS; i++) tbid_prog_mem_inst.load(4'(i), rows[i].word);
    repeat (4) @(posedge clk_i);
    #1;
    check_vec({phase_o, valid_o, group_o}, {2'h0, 1'h0, 3'h1}, "reset state");
    @(posedge clk_i);
    rst_i <= 1'b0;
    for (int i = 0; i < NROWS; i++) run_row(rows[i], 4'(i));
    // Phase counter must step through all four phases, fetch strobe in phase 3 and execute strobe in phase 0
    @(posedge clk_i);
    #1;
    ph = phase_o;
    for (int k = 0; k < 8; k++) begin
      @(posedge clk_i);
      #1;
      ph = ph + 2'h1;
      check_vec({exec_o, fetch_o, phase_o}, {ph == 2'h0, ph == 2'h3, ph}, "phase strobes");
    end
    // Reset in mid-run, then the cadence restarts from phase zero
    @(posedge clk_i);
    rst_i <= 1'b1;
    @(posedge clk_i);
    #1;
    check_vec({phase_o, valid_o, group_o, two_cycle_o, flush_o}, {2'h0, 1'h0, 3'h1, 2'h0}, "mid reset");
    @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    #1;
    check_vec(phase_o, 2'h1, "first phase");
    run_row(rows[6], 4'h6);
    finish_test();
  end
endmodule // testbench
